// file: icache_lookup.sv
// Behaviour
// - No hardware coherency; only explicit invalidation.
// - Invalidated line is refetched on next reference.
// - Real index, virtual tag; synonyms may coexist.
// - Virtual address: effective address, identifier, space.
// - Bits 27:31 byte, 23:26 set select.
// - Tag: address 0:22, identifier, instruction space.
// - Maintenance lookups use the data space bit.
// - Hit compares tag with every way of set.
// - Index uses only untranslated bits 22:31.
// - No allocation from non-executable or inhibited pages.
// - Block invalidate clears only the matching line.
// - Flash invalidate all lines, privileged only.
// - Privileged debug read copies tag and data.
// - Block touch starts fill of addressed line.
// - Block operations act on at most one line.
// - Reset flash invalidates, marks reset page inhibited.
// - Touch fill lowest priority, abandoned by miss until granted.
`timescale 1ns/10ps
`include "icl_defines.svh"
module icache_lookup
    import icl_pkg::*;
(
    // Clock and reset
    input wire logic ref_clk_i,
    input wire logic sys_rst_i,
    // Fetch
    input wire logic fetch_req_i,
    input wire logic [31:0] fetch_ea_i,
    input wire logic instruction_space_bit_i,
    input wire logic fetch_exec_i,
    input wire logic fetch_inhibit_i,
    output logic fetch_hit_o,
    output logic fetch_miss_o,
    output logic [31:0] fetch_word_o,
    // Context
    input wire logic [7:0] process_identifier_i,
    input wire logic data_space_bit_i,
    input wire logic privileged_i,
    // Maintenance
    input wire logic op_valid_i,
    input wire op_type op_code_i,
    input wire logic [31:0] op_ea_i,
    input wire logic op_exec_i,
    input wire logic op_inhibit_i,
    output logic op_done_o,
    output logic op_priv_err_o,
    output tag_type dbg_tag_o,
    output logic dbg_valid_o,
    output logic [31:0] dbg_word_o,
    // Line fill
    input wire logic fill_ack_i,
    input wire logic fill_data_valid_i,
    input wire logic [`ICL_LINE_W-1:0] fill_data_i,
    output logic fill_req_o,
    output logic [31:0] fill_addr_o,
    output logic fill_touch_o,
    output logic fill_cancel_o,
    // Reset page attribute
    input wire logic reset_inhibit_clr_i,
    output logic reset_page_inhibit_o
);

    // ****************************************
    // Arrays and lookup
    // ****************************************
    // Only valid bits are flash cleared; tag and data arrays need no reset.
    tag_type [`ICL_WAYS-1:0] tag_mem [`ICL_SETS];
    logic [`ICL_LINE_W-1:0] data_mem [`ICL_SETS][`ICL_WAYS];
    state_type s_q;
    state_type s_d;
    logic wr_en;
    tag_type f_tag;
    tag_type o_tag;
    logic [`ICL_SET_W-1:0] f_set;
    logic [`ICL_SET_W-1:0] o_set;
    logic [`ICL_WAY_W:0] f_look;
    logic [`ICL_WAY_W:0] o_look;
    logic [31:0] hit_word;
    logic start_fetch;

    function automatic tag_type make_tag(input logic [31:0] ea, input logic [7:0] process_identifier,
                                         input logic space);
        tag_type t;
        t.ea_hi = ea[31:`ICL_TAG_LSB];
        t.process_identifier = process_identifier;
        t.space = space;
        return t;
    endfunction

    function automatic logic [`ICL_WAY_W:0] lookup(input tag_type [`ICL_WAYS-1:0] row,
                                                   input logic [`ICL_WAYS-1:0] vld,
                                                   input tag_type t);
        logic [`ICL_WAY_W:0] r;
        r = '0;
        for (int w = 0; w < `ICL_WAYS; w++) begin
            if (vld[w] && row[w] == t) begin
                r = {1'b1, w[`ICL_WAY_W-1:0]};
            end
        end
        return r;
    endfunction

    function automatic logic [31:0] pick_word(input logic [`ICL_LINE_W-1:0] line,
                                              input logic [31:0] ea);
        return line[32*ea[`ICL_WORD_MSB:`ICL_WORD_LSB] +: 32];
    endfunction

    assign f_tag = make_tag(fetch_ea_i, process_identifier_i, instruction_space_bit_i);
    assign o_tag = make_tag(op_ea_i, process_identifier_i, data_space_bit_i);
    assign f_set = fetch_ea_i[`ICL_SET_MSB:`ICL_SET_LSB];
    assign o_set = op_ea_i[`ICL_SET_MSB:`ICL_SET_LSB];
    assign f_look = lookup(tag_mem[f_set], s_q.valid[f_set], f_tag);
    assign o_look = lookup(tag_mem[o_set], s_q.valid[o_set], o_tag);
    assign hit_word = pick_word(data_mem[f_set][f_look[`ICL_WAY_W-1:0]], fetch_ea_i);
    assign start_fetch = fetch_req_i && !f_look[`ICL_WAY_W] &&
                         (s_q.fsm == FSM_IDLE ||
                          (s_q.fsm == FSM_REQ && s_q.fill_touch && !fill_ack_i));
    assign wr_en = s_q.fsm == FSM_WAIT && fill_data_valid_i && s_q.fill_alloc;

    // ****************************************
    // Next state
    // ****************************************
    always_comb begin
        s_d = s_q;
        s_d.hit = 1'b0;
        s_d.miss = 1'b0;
        s_d.done = 1'b0;
        s_d.priv_err = 1'b0;
        s_d.cancel = 1'b0;
        if (reset_inhibit_clr_i) begin
            s_d.reset_ci = 1'b0;
        end
        if (s_q.fsm == FSM_REQ && fill_ack_i) begin
            s_d.fsm = FSM_WAIT;
        end
        if (s_q.fsm == FSM_WAIT && fill_data_valid_i) begin
            s_d.fsm = FSM_IDLE;
            if (!s_q.fill_touch) begin
                s_d.hit = 1'b1;
                s_d.word = pick_word(fill_data_i, s_q.fill_ea);
            end
            if (s_q.fill_alloc) begin
                s_d.valid[s_q.fill_ea[`ICL_SET_MSB:`ICL_SET_LSB]][s_q.victim] = 1'b1;
                s_d.victim = s_q.victim + 1'b1;
            end
        end
        if (fetch_req_i && f_look[`ICL_WAY_W]) begin
            s_d.hit = 1'b1;
            s_d.word = hit_word;
        end else if (fetch_req_i) begin
            s_d.miss = 1'b1;
        end
        if (start_fetch) begin
            s_d.cancel = s_q.fsm == FSM_REQ;
            s_d.fsm = FSM_REQ;
            s_d.fill_ea = fetch_ea_i;
            s_d.fill_tag = f_tag;
            s_d.fill_touch = 1'b0;
            s_d.fill_alloc = fetch_exec_i && !fetch_inhibit_i;
        end
        if (op_valid_i) begin
            s_d.done = 1'b1;
            unique case (op_code_i)
                OP_INVAL_BLOCK: begin
                    if (o_look[`ICL_WAY_W]) begin
                        s_d.valid[o_set][o_look[`ICL_WAY_W-1:0]] = 1'b0;
                    end
                end
                OP_TOUCH: begin
                    // A touch that finds the fill engine busy is a dropped hint.
                    if (!o_look[`ICL_WAY_W] && op_exec_i && !op_inhibit_i &&
                        s_q.fsm == FSM_IDLE && !start_fetch) begin
                        s_d.fsm = FSM_REQ;
                        s_d.fill_ea = op_ea_i;
                        s_d.fill_tag = o_tag;
                        s_d.fill_touch = 1'b1;
                        s_d.fill_alloc = 1'b1;
                    end
                end
                OP_INVAL_ALL: begin
                    if (privileged_i) begin
                        s_d.valid = '0;
                    end else begin
                        s_d.priv_err = 1'b1;
                    end
                end
                OP_READ: begin
                    if (privileged_i) begin
                        s_d.dbg_tag = tag_mem[o_set][op_ea_i[`ICL_WAY_MSB:`ICL_WAY_LSB]];
                        s_d.dbg_valid = s_q.valid[o_set][op_ea_i[`ICL_WAY_MSB:`ICL_WAY_LSB]];
                        s_d.dbg_word = pick_word(
                            data_mem[o_set][op_ea_i[`ICL_WAY_MSB:`ICL_WAY_LSB]], op_ea_i);
                    end else begin
                        s_d.priv_err = 1'b1;
                    end
                end
            endcase
        end
    end

    // ****************************************
    // Registers
    // ****************************************
    always_ff @(posedge ref_clk_i) begin
        if (sys_rst_i) begin
            s_q <= '0;
            s_q.fsm <= FSM_IDLE;
            s_q.reset_ci <= 1'b1;
        end else begin
            s_q <= s_d;
        end
    end

    always_ff @(posedge ref_clk_i) begin
        if (wr_en) begin
            tag_mem[s_q.fill_ea[`ICL_SET_MSB:`ICL_SET_LSB]][s_q.victim] <= s_q.fill_tag;
            data_mem[s_q.fill_ea[`ICL_SET_MSB:`ICL_SET_LSB]][s_q.victim] <= fill_data_i;
        end
    end

    assign fetch_hit_o = s_q.hit;
    assign fetch_miss_o = s_q.miss;
    assign fetch_word_o = s_q.word;
    assign op_done_o = s_q.done;
    assign op_priv_err_o = s_q.priv_err;
    assign dbg_tag_o = s_q.dbg_tag;
    assign dbg_valid_o = s_q.dbg_valid;
    assign dbg_word_o = s_q.dbg_word;
    assign fill_req_o = s_q.fsm[1];
    assign fill_addr_o = {s_q.fill_ea[31:`ICL_LINE_LSB], 5'h00};
    assign fill_touch_o = s_q.fill_touch;
    assign fill_cancel_o = s_q.cancel;
    assign reset_page_inhibit_o = s_q.reset_ci;

    // ****************************************
    // Checks
    // ****************************************
    default clocking cb @(posedge ref_clk_i); endclocking
    default disable iff (sys_rst_i);

    logic no_fill_ret;
    assign no_fill_ret = !(s_q.fsm == FSM_WAIT && fill_data_valid_i);

    sequence touch_pending;
        s_q.fsm == FSM_REQ && s_q.fill_touch && !fill_ack_i;
    endsequence
    sequence fetch_misses;
        fetch_req_i && !f_look[`ICL_WAY_W];
    endsequence

    a_reset_flash: assert property (@(posedge ref_clk_i) disable iff (1'b0)
        sys_rst_i |=> s_q.valid == '0 && reset_page_inhibit_o)
        else $error("reset did not flash invalidate");
    a_flash_all: assert property (op_valid_i && op_code_i == OP_INVAL_ALL && privileged_i
        |=> s_q.valid == '0 && op_done_o)
        else $error("flash invalidate left valid lines");
    a_flash_unpriv: assert property (op_valid_i && op_code_i == OP_INVAL_ALL && !privileged_i
        && no_fill_ret |=> op_priv_err_o && s_q.valid == $past(s_q.valid))
        else $error("unprivileged flash invalidate acted");
    a_read_unpriv: assert property (op_valid_i && op_code_i == OP_READ && !privileged_i
        |=> op_priv_err_o && dbg_tag_o == $past(dbg_tag_o))
        else $error("unprivileged debug read acted");
    a_no_alloc: assert property (s_q.fsm == FSM_WAIT && fill_data_valid_i && !s_q.fill_alloc
        |=> (s_q.valid & ~$past(s_q.valid)) == '0)
        else $error("inhibited line allocated");
    a_touch_abandon: assert property (touch_pending ##0 fetch_misses
        |=> fill_req_o && !fill_touch_o && fill_cancel_o)
        else $error("touch fill not abandoned");
    a_inval_match: assert property (op_valid_i && op_code_i == OP_INVAL_BLOCK &&
        o_look[`ICL_WAY_W] |=> !s_q.valid[$past(o_set)][$past(o_look[`ICL_WAY_W-1:0])])
        else $error("matching line still valid");
    a_inval_miss: assert property (op_valid_i && op_code_i == OP_INVAL_BLOCK &&
        !o_look[`ICL_WAY_W] && no_fill_ret |=> s_q.valid == $past(s_q.valid))
        else $error("missing invalidate changed cache");
    a_miss_fill: assert property (fetch_misses ##0 s_q.fsm == FSM_IDLE
        |=> fill_req_o && fill_addr_o == {$past(fetch_ea_i[31:5]), 5'h00})
        else $error("miss did not request fill");
    a_hit_word: assert property (fetch_req_i && f_look[`ICL_WAY_W]
        |=> fetch_hit_o && fetch_word_o == $past(hit_word))
        else $error("hit word wrong");

endmodule // icache_lookup

// file: icl_defines.svh
`ifndef ICL_DEFINES_SVH
`define ICL_DEFINES_SVH
`define ICL_SETS 16
`define ICL_WAYS 64
`define ICL_WAY_W 6
`define ICL_SET_W 4
`define ICL_LINE_W 256
`define ICL_SET_LSB 5
`define ICL_SET_MSB 8
`define ICL_TAG_LSB 9
`define ICL_WAY_LSB 9
`define ICL_WAY_MSB 14
`define ICL_WORD_LSB 2
`define ICL_WORD_MSB 4
`define ICL_LINE_LSB 5
`endif

// file: icl_pkg.sv
`include "icl_defines.svh"
package icl_pkg;
    typedef struct packed {
        logic [22:0] ea_hi;
        logic [7:0] process_identifier;
        logic space;
    } tag_type;
    typedef enum logic [2:0] {
        FSM_IDLE = 3'b001,
        FSM_REQ = 3'b010,
        FSM_WAIT = 3'b100
    } fsm_type;
    typedef enum logic [1:0] {
        OP_INVAL_BLOCK = 2'h0,
        OP_TOUCH = 2'h1,
        OP_INVAL_ALL = 2'h2,
        OP_READ = 2'h3
    } op_type;
    typedef struct packed {
        fsm_type fsm;
        logic [`ICL_SETS-1:0][`ICL_WAYS-1:0] valid;
        logic [`ICL_WAY_W-1:0] victim;
        logic [31:0] fill_ea;
        tag_type fill_tag;
        logic fill_touch;
        logic fill_alloc;
        logic hit;
        logic miss;
        logic [31:0] word;
        logic done;
        logic priv_err;
        logic cancel;
        tag_type dbg_tag;
        logic dbg_valid;
        logic [31:0] dbg_word;
        logic reset_ci;
    } state_type;
endpackage

// file: icl_fill_model.sv
`timescale 1ns/10ps
`include "icl_defines.svh"
module icl_fill_model
    import icl_pkg::*;
(
    // Clock and reset
    input wire logic ref_clk_i,
    input wire logic sys_rst_i,
    // Pace of the answer
    input wire logic slow_i,
    // Fill request
    input wire logic fill_req_i,
    input wire logic [31:0] fill_addr_i,
    // Fill answer
    output logic fill_ack_o,
    output logic fill_data_valid_o,
    output logic [`ICL_LINE_W-1:0] fill_data_o
);
    logic busy_q;
    logic [4:0] cnt_q;
    logic [31:0] addr_q;

    function automatic logic [`ICL_LINE_W-1:0] line_of(input logic [31:0] a);
        logic [`ICL_LINE_W-1:0] d;
        for (int k = 0; k < 8; k++) begin
            d[32*k +: 32] = {a[31:5], k[2:0], 2'b00} ^ 32'h5a5a_0000;
        end
        return d;
    endfunction

    // The data lines toggle every cycle outside a beat, so a stale line is never reused.
    // Slow mode grants late enough that a fetch miss can still overtake a pending touch.
    always_ff @(posedge ref_clk_i) begin
        fill_ack_o <= 1'b0;
        fill_data_valid_o <= 1'b0;
        fill_data_o <= ~fill_data_o;
        if (sys_rst_i) begin
            busy_q <= 1'b0;
            cnt_q <= 5'h00;
            fill_data_o <= '0;
        end else if (!busy_q) begin
            if (!fill_req_i) begin
                cnt_q <= 5'h00;
            end else if (cnt_q >= (slow_i ? 5'h10 : 5'h00)) begin
                fill_ack_o <= 1'b1;
                addr_q <= fill_addr_i;
                busy_q <= 1'b1;
                cnt_q <= 5'h00;
            end else begin
                cnt_q <= cnt_q + 5'h01;
            end
        end else if (cnt_q == (slow_i ? 5'h04 : 5'h01)) begin
            fill_data_valid_o <= 1'b1;
            fill_data_o <= line_of(addr_q);
            busy_q <= 1'b0;
            cnt_q <= 5'h00;
        end else begin
            cnt_q <= cnt_q + 5'h01;
        end
    end
endmodule // icl_fill_model

// file: tb_top.sv
`timescale 1ns/10ps
`include "icl_defines.svh"
module tb_top
    import icl_pkg::*;
;
    logic ref_clk_i = 1'b0;
    logic sys_rst_i = 1'b1;
    logic fetch_req_i, isp_i, fetch_exec_i, fetch_inhibit_i, dsp_i, priv_i, op_valid_i;
    logic op_exec_i, op_inhibit_i, fill_ack_i, fill_dv_i, clr_i, slow_i;
    logic fetch_hit_o, fetch_miss_o, op_done_o, op_priv_err_o, dbg_valid_o, fill_req_o;
    logic fill_touch_o, fill_cancel_o, reset_page_inhibit_o;
    logic [31:0] fetch_ea_i, op_ea_i, fetch_word_o, dbg_word_o, fill_addr_o, a;
    logic [7:0] pid_i;
    logic [`ICL_LINE_W-1:0] fill_data_i;
    op_type op_code_i;
    tag_type dbg_tag_o;
    bit cached [bit [35:0]];
    int error_cnt, tests_run, cancel_cnt, seed;

    icache_lookup uut (.ref_clk_i(ref_clk_i), .sys_rst_i(sys_rst_i), .fetch_req_i(fetch_req_i),
        .fetch_ea_i(fetch_ea_i), .instruction_space_bit_i(isp_i), .fetch_exec_i(fetch_exec_i),
        .fetch_inhibit_i(fetch_inhibit_i), .fetch_hit_o(fetch_hit_o), .fetch_miss_o(fetch_miss_o),
        .fetch_word_o(fetch_word_o), .process_identifier_i(pid_i), .data_space_bit_i(dsp_i),
        .privileged_i(priv_i), .op_valid_i(op_valid_i), .op_code_i(op_code_i), .op_ea_i(op_ea_i),
        .op_exec_i(op_exec_i), .op_inhibit_i(op_inhibit_i), .op_done_o(op_done_o),
        .op_priv_err_o(op_priv_err_o), .dbg_tag_o(dbg_tag_o), .dbg_valid_o(dbg_valid_o),
        .dbg_word_o(dbg_word_o), .fill_ack_i(fill_ack_i), .fill_data_valid_i(fill_dv_i),
        .fill_data_i(fill_data_i), .fill_req_o(fill_req_o), .fill_addr_o(fill_addr_o),
        .fill_touch_o(fill_touch_o), .fill_cancel_o(fill_cancel_o),
        .reset_inhibit_clr_i(clr_i), .reset_page_inhibit_o(reset_page_inhibit_o));
    icl_fill_model far (.ref_clk_i(ref_clk_i), .sys_rst_i(sys_rst_i), .slow_i(slow_i),
        .fill_req_i(fill_req_o), .fill_addr_i(fill_addr_o), .fill_ack_o(fill_ack_i),
        .fill_data_valid_o(fill_dv_i), .fill_data_o(fill_data_i));

    always #50 ref_clk_i = ~ref_clk_i;
    always @(posedge ref_clk_i) if (fill_cancel_o === 1'b1) cancel_cnt++;

    // ****************************************
    // Shared tasks
    // ****************************************
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        tests_run++;
        if (seen !== exp) begin
            error_cnt++;
            $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask

    task automatic ctx(input logic [7:0] p, input logic s, input logic d, input logic pv);
        @(posedge ref_clk_i);
        pid_i <= p;
        isp_i <= s;
        dsp_i <= d;
        priv_i <= pv;
        // Let the new context settle before a caller reads it for its expectation.
        #1;
    endtask

    task automatic fetch(input logic [31:0] ea, input logic ex, input logic inh);
        bit [35:0] k;
        logic h;
        int n;
        k = {isp_i, pid_i, ea[31:5]};
        h = cached.exists(k);
        @(posedge ref_clk_i);
        fetch_ea_i <= ea;
        fetch_exec_i <= ex;
        fetch_inhibit_i <= inh;
        fetch_req_i <= 1'b1;
        @(posedge ref_clk_i);
        fetch_req_i <= 1'b0;
        #1;
        check(fetch_hit_o, h);
        check(fetch_miss_o, !h);
        n = 0;
        while (fetch_hit_o !== 1'b1 && n < 20) begin
            @(posedge ref_clk_i);
            #1;
            n++;
        end
        check(n < 20, 1'b1);
        if (ex && !inh) cached[k] = 1'b1;
        check(fetch_word_o, {ea[31:2], 2'b00} ^ 32'h5a5a_0000);
    endtask

    task automatic op(input op_type c, input logic [31:0] ea, input logic ex, input logic inh);
        logic err;
        bit [35:0] k;
        err = (c == OP_INVAL_ALL || c == OP_READ) && !priv_i;
        k = {dsp_i, pid_i, ea[31:5]};
        @(posedge ref_clk_i);
        op_valid_i <= 1'b1;
        op_code_i <= c;
        op_ea_i <= ea;
        op_exec_i <= ex;
        op_inhibit_i <= inh;
        @(posedge ref_clk_i);
        op_valid_i <= 1'b0;
        #1;
        check(op_done_o, 1'b1);
        check(op_priv_err_o, err);
        if (!err && c == OP_INVAL_BLOCK) cached.delete(k);
        if (!err && c == OP_INVAL_ALL) cached.delete();
        if (c == OP_TOUCH && ex && !inh) cached[k] = 1'b1;
        repeat (12) @(posedge ref_clk_i);
    endtask

    task automatic find(input logic [31:0] ea, input logic [31:0] tag, input int want);
        int c;
        c = 0;
        for (int w = 0; w < `ICL_WAYS; w++) begin
            op(OP_READ, {17'h0, w[5:0], ea[8:2], 2'b00}, 1'b0, 1'b0);
            if (dbg_valid_o === 1'b1 && dbg_tag_o === tag) begin
                c++;
                check(dbg_word_o, {ea[31:2], 2'b00} ^ 32'h5a5a_0000);
            end
        end
        check(c, want);
    endtask

    task automatic print_verdict;
        $display("checks %0d, mismatches %0d", tests_run, error_cnt);
        if (error_cnt == 0 && tests_run > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask

    // ****************************************
    // Main sequence
    // ****************************************
    initial begin
        {fetch_req_i, isp_i, fetch_exec_i, fetch_inhibit_i, dsp_i, priv_i} = '0;
        {op_valid_i, op_exec_i, op_inhibit_i, clr_i, slow_i, pid_i} = '0;
        {fetch_ea_i, op_ea_i} = '0;
        op_code_i = OP_INVAL_BLOCK;
        seed = $urandom(84);
        repeat (5) @(posedge ref_clk_i);
        sys_rst_i <= 1'b0;
        @(posedge ref_clk_i);
        #1;
        check(reset_page_inhibit_o, 1'b1);
        clr_i <= 1'b1;
        @(posedge ref_clk_i);
        clr_i <= 1'b0;
        @(posedge ref_clk_i);
        #1;
        check(reset_page_inhibit_o, 1'b0);
        $display("test reset finished");
        for (int i = 0; i < 8; i++) begin
            ctx(8'($urandom), 1'($urandom & 1), 1'b0, 1'b1);
            a = $urandom;
            fetch(a, i % 4 != 1, i % 4 == 2);
            fetch({a[31:5], 5'h0} | ($urandom & 32'h1c), 1'b1, 1'b0);
        end
        $display("test fetch finished");
        a = $urandom;
        ctx(8'h11, 1'b0, 1'b0, 1'b1);
        fetch(a, 1'b1, 1'b0);
        ctx(8'h22, 1'b0, 1'b1, 1'b1);
        fetch(a, 1'b1, 1'b0);
        find(a, {a[31:9], 8'h22, 1'b0}, 1);
        ctx(8'h11, 1'b0, 1'b1, 1'b1);
        op(OP_INVAL_BLOCK, a, 1'b0, 1'b0);
        fetch(a, 1'b1, 1'b0);
        ctx(8'h11, 1'b0, 1'b0, 1'b0);
        op(OP_INVAL_BLOCK, a, 1'b0, 1'b0);
        op(OP_READ, a, 1'b0, 1'b0);
        ctx(8'h22, 1'b0, 1'b0, 1'b0);
        fetch(a, 1'b1, 1'b0);
        ctx(8'h11, 1'b0, 1'b0, 1'b0);
        fetch(a, 1'b1, 1'b0);
        $display("test synonym finished");
        a = $urandom;
        op(OP_TOUCH, a, 1'b1, 1'b1);
        fetch(a, 1'b1, 1'b0);
        op(OP_TOUCH, a ^ 32'h0000_1000, 1'b1, 1'b0);
        fetch(a ^ 32'h0000_1000, 1'b1, 1'b0);
        slow_i <= 1'b1;
        seed = cancel_cnt;
        op(OP_TOUCH, a ^ 32'h0000_2000, 1'b1, 1'b0);
        cached.delete({dsp_i, pid_i, a[31:5] ^ 27'h100});
        fetch(a ^ 32'h0000_3000, 1'b1, 1'b0);
        check(cancel_cnt - seed, 1);
        slow_i <= 1'b0;
        fetch(a ^ 32'h0000_2000, 1'b1, 1'b0);
        $display("test touch finished");
        op(OP_INVAL_ALL, a, 1'b0, 1'b0);
        fetch(a ^ 32'h0000_3000, 1'b1, 1'b0);
        ctx(8'h11, 1'b0, 1'b0, 1'b1);
        op(OP_INVAL_ALL, a, 1'b0, 1'b0);
        fetch(a ^ 32'h0000_3000, 1'b1, 1'b0);
        $display("test flash finished");
        print_verdict();
    end

    // The limit lies far beyond the length of the whole sequence, so only a hang reaches it.
    initial begin
        repeat (20000) @(posedge ref_clk_i);
        error_cnt++;
        print_verdict();
    end
endmodule // tb_top
